// *** design/afs_pkg.sv ***
// Constants shared by the converter front-end serial slave.
// Assumes a 100 MHz system clock and a host-driven serial clock.
package afs_pkg;
    // -----------------------------------------------------------------
    // Timing
    // -----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int READY_LEAD_NS = 2200;
    // Longest wait, so it rounds down.
    localparam int READY_LEAD_CYC = READY_LEAD_NS / CLK_PERIOD_NS;
    localparam int SOFT_RESET_ONES = 64;
    // -----------------------------------------------------------------
    // Command and frame layout
    // -----------------------------------------------------------------
    localparam int CMD_MAP_BIT = 7;
    localparam int CMD_RW_BIT = 6;
    localparam int CMD_DEV_LO = 4;
    localparam int CMD_BITS = 8;
    localparam int DATA_BITS = 16;
    localparam int RES_BITS = 24;
    localparam int CRC_BITS = 8;
    // -----------------------------------------------------------------
    // Register indices and fields
    // -----------------------------------------------------------------
    localparam logic [3:0] FE_STATUS_IDX = 4'h0;
    localparam logic [3:0] FE_CTRL1_IDX = 4'h1;
    localparam logic [3:0] CV_STATUS_IDX = 4'h0;
    localparam logic [3:0] CV_IFACE_IDX = 4'h2;
    localparam logic [3:0] CV_RESULT_IDX = 4'h4;
    localparam int FE_CRC_EN_LO = 13;
    localparam int CV_CRC_EN_LO = 2;
    localparam logic [1:0] CV_CRC_XOR = 2'h1;
    localparam int FE_CRC_ERR_BIT = 4;
    localparam int CV_CRC_ERR_BIT = 5;
    localparam logic [15:0] REG_RESET = 16'h0000;
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [7:0] CRC_INIT = 8'h00;
    // -----------------------------------------------------------------
    // State encodings
    // -----------------------------------------------------------------
    typedef enum logic [2:0] {
        AFS_CMD = 3'h0, AFS_WDATA = 3'h1, AFS_WCRC = 3'h3,
        AFS_HALT = 3'h7, AFS_RDATA = 3'h4
    } afs_frame_e;
    typedef enum logic {AFS_IDLE = 1'h0, AFS_LEAD = 1'h1} afs_core_e;
endpackage

// *** design/afs_spi_slave.sv ***
// Serial slave of the converter front end: framing, maps, checksum, ready.
// Assumes sclk only toggles while cs_n is low and the straps are static.
// Notes on behaviour
// - Output released whenever chip select high.
// - Output bits change on falling clock edges.
// - Idle pin falls low on fresh result.
// - Pin rises 2.2 us before next update.
// - Result arriving during result read is dropped.
// - Write: command, 16-bit word, optional checksum.
// - Front-end registers are all 16 bits.
// - Checksum needs enable fields in both maps.
// - Bad checksum: no write, error bit set.
// - Short write frame writes nothing.
// - Read: command, data, optional checksum.
// - Pin switches to data after command byte.
// - Read checksum covers command and sent data.
// - Short read frame is simply abandoned.
// - One device per frame, select bits fixed.
// - Address 00 owns pin until select decoded.
// - Command holds map, direction, select, index.
// - Foreign select bits: ignore rest of frame.
// - 64 consecutive ones reset the frame and both maps.
// - Polynomial x8+x2+x+1; converter reads may XOR.
`timescale 1ns/10ps
module afs_spi_slave (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    output logic dout_o,
    output logic dout_oe_n,
    input wire logic strap_select_low,
    input wire logic strap_select_high,
    input wire logic conv_result_valid,
    input wire logic [afs_pkg::RES_BITS-1:0] conv_result
);
    import afs_pkg::*;

    // -----------------------------------------------------------------
    // State records; frame and maps share rising sclk.
    // -----------------------------------------------------------------
    // Frame state; cleared by every chip select rise.
    typedef struct packed {
        afs_frame_e state;
        logic [5:0] cnt;
        logic [23:0] sh;
        logic [7:0] rxc;
        logic [7:0] crc;
        logic claimed;
        logic owner;
        logic res_rd;
        logic [31:0] rd_word;
        logic [5:0] rd_len;
        logic [6:0] ones;
    } afs_frame_s;
    // Register maps; survive frames, cleared by reset or 64 ones.
    typedef struct packed {
        logic [15:0][15:0] fe;
        logic [15:0][15:0] cv;
        logic fe_err;
        logic cv_err;
        logic [1:0] strap_m;
        logic [1:0] strap_s;
    } afs_regs_s;
    // Falling-edge output shifter.
    typedef struct packed {
        logic shifting;
        logic [31:0] sh;
        logic [5:0] rem;
        logic dout;
    } afs_tx_s;
    // System-clock result keeper and ready level.
    typedef struct packed {
        afs_core_e state;
        logic [7:0] cnt;
        logic rdy_n;
        logic [23:0] result;
        logic [23:0] hold;
        logic busy_m;
        logic busy_s;
        logic busy_p;
    } afs_core_s;

    afs_frame_s f_q, f_d;
    afs_regs_s r_q, r_d;
    afs_tx_s t_q, t_d;
    afs_core_s c_q, c_d;
    logic crc_en; // Both maps enable the checksum.
    logic xor_mode; // Converter reads use the bytewise XOR.
    logic soft_rst; // Sixty-fourth consecutive one.
    logic owner; // This device drives the shared pin.
    logic wr_en; // Commit a received word this edge.
    logic err_en; // Checksum mismatch this edge.
    logic commit; // Result update moment.

    // -----------------------------------------------------------------
    // Checksum helpers.
    // -----------------------------------------------------------------
    // One serial step of the x8+x2+x+1 divider, MSB first.
    function automatic logic [7:0] crc_step(input logic [7:0] c, input logic b);
        crc_step = {c[6:0], 1'b0} ^ ((c[7] ^ b) ? CRC_POLY : 8'h00);
    endfunction

    // Polynomial checksum over the first n bits of v.
    function automatic logic [7:0] crc_poly(input logic [31:0] v, input int n);
        logic [7:0] c;
        c = CRC_INIT;
        for (int i = 0; i < 32; i++)
        begin
            if (i < n)
            begin
                c = crc_step(c, v[31-i]);
            end
        end
        crc_poly = c;
    endfunction

    assign crc_en = (|r_q.fe[FE_CTRL1_IDX][FE_CRC_EN_LO+:2])
        && (|r_q.cv[CV_IFACE_IDX][CV_CRC_EN_LO+:2]);
    assign xor_mode = r_q.cv[CV_IFACE_IDX][CV_CRC_EN_LO+:2] == CV_CRC_XOR;
    assign soft_rst = din && (f_q.ones == 7'(SOFT_RESET_ONES - 1));
    // Address 00 holds the pin until a nonzero select is decoded.
    assign owner = f_q.claimed ? f_q.owner : (r_q.strap_s == 2'h0);

    // -----------------------------------------------------------------
    // Frame decoder, rising sclk.
    // -----------------------------------------------------------------
    // Shifts command and data in, decides the frame's fate at bit 8.
    always_comb
    begin
        logic [7:0] cmd;
        logic [3:0] idx;
        logic [23:0] rd;
        logic long_rd;
        logic [7:0] ck;
        cmd = {f_q.sh[6:0], din};
        idx = cmd[3:0];
        rd = 24'h0;
        long_rd = 1'b0;
        ck = 8'h00;
        f_d = f_q;
        wr_en = 1'b0;
        err_en = 1'b0;
        f_d.ones = din ? f_q.ones + 7'h1 : 7'h0;
        f_d.cnt = f_q.cnt + 6'h1;
        unique case (f_q.state)
            AFS_CMD:
            begin
                f_d.sh = {f_q.sh[22:0], din};
                f_d.crc = crc_step(f_q.crc, din);
                if (f_q.cnt == 6'(CMD_BITS - 1))
                begin
                    // Fields: map, direction, select, index.
                    if (cmd[CMD_DEV_LO+:2] != 2'h0)
                    begin
                        f_d.claimed = 1'b1;
                        f_d.owner = cmd[CMD_DEV_LO+:2] == r_q.strap_s;
                    end
                    if (cmd[CMD_DEV_LO+:2] != r_q.strap_s)
                    begin
                        f_d.state = AFS_HALT;
                    end
                    else if (cmd[CMD_RW_BIT])
                    begin
                        // Read: pick the word, append the checksum.
                        if (cmd[CMD_MAP_BIT])
                        begin
                            rd[23:8] = (idx == FE_STATUS_IDX)
                                ? 16'(r_q.fe_err) << FE_CRC_ERR_BIT : r_q.fe[idx];
                        end
                        else if (idx == CV_RESULT_IDX)
                        begin
                            rd = c_q.result;
                            long_rd = 1'b1;
                            f_d.res_rd = 1'b1;
                        end
                        else
                        begin
                            rd[23:8] = (idx == CV_STATUS_IDX)
                                ? 16'(r_q.cv_err) << CV_CRC_ERR_BIT : r_q.cv[idx];
                        end
                        if (!cmd[CMD_MAP_BIT] && xor_mode)
                        begin
                            ck = cmd ^ rd[23:16] ^ rd[15:8] ^ (long_rd ? rd[7:0] : 8'h00);
                        end
                        else
                        begin
                            ck = crc_poly({cmd, rd}, long_rd ? 32 : 24);
                        end
                        f_d.rd_word = long_rd ? {rd, ck} : {rd[23:8], ck, 8'h00};
                        f_d.rd_len = 6'(long_rd ? RES_BITS : DATA_BITS)
                            + (crc_en ? 6'(CRC_BITS) : 6'h0);
                        f_d.state = AFS_RDATA;
                    end
                    else
                    begin
                        f_d.state = AFS_WDATA;
                    end
                end
            end
            AFS_WDATA:
            begin
                f_d.sh = {f_q.sh[22:0], din};
                f_d.crc = crc_step(f_q.crc, din);
                if (f_q.cnt == 6'(CMD_BITS + DATA_BITS - 1))
                begin
                    f_d.state = crc_en ? AFS_WCRC : AFS_HALT;
                    wr_en = !crc_en;
                end
            end
            AFS_WCRC:
            begin
                f_d.rxc = {f_q.rxc[6:0], din};
                if (f_q.cnt == 6'(CMD_BITS + DATA_BITS + CRC_BITS - 1))
                begin
                    f_d.state = AFS_HALT;
                    wr_en = f_d.rxc == f_q.crc;
                    err_en = !wr_en;
                end
            end
            AFS_RDATA, AFS_HALT:
            begin
                // Input is ignored for the rest of the frame, except that consecutive ones are still counted.
                f_d.cnt = f_q.cnt;
            end
            default:
            begin
                f_d.state = AFS_HALT;
            end
        endcase
        if (soft_rst)
        begin
            // Back to awaiting a command; maps reset alongside.
            f_d.state = AFS_CMD;
            f_d.cnt = 6'h0;
            f_d.crc = CRC_INIT;
            f_d.ones = 7'h0;
            wr_en = 1'b0;
            err_en = 1'b0;
        end
    end

    // Raising cs_n clears the frame, so short frames commit nothing.
    always_ff @(posedge sclk or negedge rst_n or posedge cs_n)
    begin
        if (!rst_n || cs_n)
        begin
            f_q <= '0;
        end
        else
        begin
            f_q <= f_d;
        end
    end

    // -----------------------------------------------------------------
    // Register maps, rising sclk.
    // -----------------------------------------------------------------
    // Straps pass two flops; status and result indices are read-only.
    always_comb
    begin
        logic [3:0] widx;
        logic wmap;
        // Without a checksum the last data bit is still arriving, so the whole
        // word is only complete in the next frame record; decode from that.
        widx = f_d.sh[DATA_BITS+:4];
        wmap = f_d.sh[DATA_BITS+CMD_MAP_BIT];
        r_d = r_q;
        r_d.strap_m = {strap_select_high, strap_select_low};
        r_d.strap_s = r_q.strap_m;
        if (wr_en && wmap)
        begin
            if (widx != FE_STATUS_IDX)
            begin
                r_d.fe[widx] = f_d.sh[15:0];
            end
        end
        else if (wr_en && widx != CV_STATUS_IDX && widx != CV_RESULT_IDX)
        begin
            r_d.cv[widx] = f_d.sh[15:0];
        end
        if (err_en)
        begin
            r_d.fe_err = r_q.fe_err | wmap;
            r_d.cv_err = r_q.cv_err | !wmap;
        end
        if (soft_rst)
        begin
            r_d.fe = {16{REG_RESET}};
            r_d.cv = {16{REG_RESET}};
            r_d.fe_err = 1'b0;
            r_d.cv_err = 1'b0;
        end
    end

    // Maps hold their contents across frames.
    always_ff @(posedge sclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            r_q <= '0;
        end
        else
        begin
            r_q <= r_d;
        end
    end

    // -----------------------------------------------------------------
    // Output shifter, falling sclk.
    // -----------------------------------------------------------------
    // Loads at the first falling edge after a read command.
    always_comb
    begin
        t_d = t_q;
        if (!t_q.shifting && f_q.state == AFS_RDATA)
        begin
            t_d.shifting = 1'b1;
            t_d.dout = f_q.rd_word[31];
            t_d.sh = {f_q.rd_word[30:0], 1'b0};
            t_d.rem = f_q.rd_len - 6'h1;
        end
        else if (t_q.shifting && t_q.rem != 6'h0)
        begin
            // Last bit stays put until the frame ends.
            t_d.dout = t_q.sh[31];
            t_d.sh = {t_q.sh[30:0], 1'b0};
            t_d.rem = t_q.rem - 6'h1;
        end
    end

    always_ff @(negedge sclk or negedge rst_n or posedge cs_n)
    begin
        if (!rst_n || cs_n)
        begin
            t_q <= '0;
        end
        else
        begin
            t_q <= t_d;
        end
    end

    // Ready level shows whenever no register is shifting out.
    assign dout_o = t_q.shifting ? t_q.dout : c_q.rdy_n;
    assign dout_oe_n = cs_n || !owner;

    // -----------------------------------------------------------------
    // Result keeper, system clock.
    // -----------------------------------------------------------------
    // The lead wait lets a host finish or defer a read before update.
    always_comb
    begin
        c_d = c_q;
        commit = 1'b0;
        c_d.busy_m = f_q.res_rd;
        c_d.busy_s = c_q.busy_m;
        c_d.busy_p = c_q.busy_s;
        if (c_q.busy_p && !c_q.busy_s)
        begin
            c_d.rdy_n = 1'b1;
        end
        if (conv_result_valid)
        begin
            c_d.hold = conv_result;
        end
        unique case (c_q.state)
            AFS_IDLE:
            begin
                if (conv_result_valid && !c_q.rdy_n)
                begin
                    c_d.rdy_n = 1'b1;
                    c_d.state = AFS_LEAD;
                    c_d.cnt = 8'(READY_LEAD_CYC - 1);
                end
                else
                begin
                    commit = conv_result_valid;
                end
            end
            AFS_LEAD:
            begin
                c_d.cnt = c_q.cnt - 8'h1;
                if (c_q.cnt == 8'h0)
                begin
                    commit = 1'b1;
                    c_d.state = AFS_IDLE;
                end
            end
        endcase
        if (commit && !c_q.busy_s)
        begin
            c_d.result = conv_result_valid ? conv_result : c_q.hold;
            c_d.rdy_n = 1'b0;
        end
        // A result landing mid-read is lost; ready stays high.
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            c_q <= '0;
        end
        else
        begin
            c_q <= c_d;
        end
    end

    // -----------------------------------------------------------------
    // Assertions.
    // -----------------------------------------------------------------
    property p_release;
        @(posedge clk) disable iff (!rst_n)
        cs_n |-> dout_oe_n && !t_q.shifting && f_q.state == AFS_CMD;
    endproperty
    a_release: assert property (p_release)
        else $error("pin driven with chip select high");

    property p_lead;
        @(posedge clk) disable iff (!rst_n)
        $rose(c_q.state == AFS_LEAD) |-> c_q.rdy_n [*8] ##1 (c_q.state == AFS_LEAD);
    endproperty
    a_lead: assert property (p_lead)
        else $error("ready lead too short");

    property p_lead_end;
        @(posedge clk) disable iff (!rst_n)
        $rose(c_q.state == AFS_LEAD) |-> ##[219:221] (c_q.state == AFS_IDLE);
    endproperty
    a_lead_end: assert property (p_lead_end)
        else $error("ready lead length wrong");

    property p_fresh;
        @(posedge clk) disable iff (!rst_n)
        (commit && !c_q.busy_s && !conv_result_valid)
        |=> !c_q.rdy_n && c_q.result == $past(c_q.hold);
    endproperty
    a_fresh: assert property (p_fresh)
        else $error("fresh result not flagged");

    property p_drop;
        @(posedge clk) disable iff (!rst_n)
        (commit && c_q.busy_s) |=> $stable(c_q.result);
    endproperty
    a_drop: assert property (p_drop)
        else $error("result updated during read");

    property p_ignore;
        @(posedge sclk) disable iff (!rst_n || cs_n)
        (f_q.state == AFS_CMD && f_q.cnt == 6'h7 && !soft_rst
            && {f_q.sh[4:3]} != r_q.strap_s) |=> f_q.state == AFS_HALT;
    endproperty
    a_ignore: assert property (p_ignore)
        else $error("foreign command not ignored");

    property p_bad_crc;
        @(posedge sclk) disable iff (!rst_n || cs_n)
        err_en |=> $stable(r_q.fe) && $stable(r_q.cv) && (r_q.fe_err || r_q.cv_err);
    endproperty
    a_bad_crc: assert property (p_bad_crc)
        else $error("bad checksum write handled wrongly");

    property p_switch;
        @(negedge sclk) disable iff (!rst_n || cs_n)
        (f_q.state == AFS_RDATA && !t_q.shifting)
        |=> t_q.shifting && dout_o == f_q.rd_word[31];
    endproperty
    a_switch: assert property (p_switch)
        else $error("read data not switched in");

    property p_soft;
        @(posedge sclk) disable iff (!rst_n || cs_n)
        soft_rst |=> r_q.fe == {16{REG_RESET}} && f_q.state == AFS_CMD;
    endproperty
    a_soft: assert property (p_soft)
        else $error("ones reset not applied");
endmodule // afs_spi_slave

// *** dv/afs_host_model.sv ***
// Host-side serial master model for the converter front-end slave.
// Assumes the bench resolves the shared output pin and hands it in.
`timescale 1ns/10ps
module afs_host_model (
    output logic sclk,
    output logic cs_n,
    output logic din,
    input wire logic pin
);
    // ----------------------------------------------------------------
    // Frame engine
    // ----------------------------------------------------------------
    // Half of the 64 ns link period.
    localparam time HALF = 32;
    // The clock parks high and stands still between frames.
    initial
    begin
        sclk = 1'b1;
        cs_n = 1'b1;
        din = 1'b0;
    end
    // Sends the low n bits of tx, most significant first, one device per frame.
    task automatic xfer(input logic [71:0] tx, input int n, output logic [71:0] rx);
        rx = '0;
        cs_n = 1'b0;
        #(HALF);
        for (int i = n - 1; i >= 0; i--)
        begin
            sclk = 1'b0;
            din = tx[i];
            #(HALF);
            // The pin has settled since the falling edge, so it is taken here.
            rx = {rx[70:0], pin};
            sclk = 1'b1;
            #(HALF);
        end
        // The ninth falling edge follows within one half period, far below
        // the ready lead, so the clock is never paused.
        cs_n = 1'b1;
        // A released data line shows the inverse of its last bit.
        din = ~din;
        #(10 * HALF);
    endtask
endmodule // afs_host_model

// *** dv/tb_adc_frontend_spi_slave.sv ***
// Self-checking bench for the converter front-end serial slave.
// Assumes the slave is alone on the bus, strapped to 00 but for one scenario.
`timescale 1ns/10ps
module tb_adc_frontend_spi_slave;
    import afs_pkg::*;
    logic clk;
    logic rst_n;
    logic conv_result_valid;
    logic [RES_BITS-1:0] conv_result;
    logic sclk;
    logic cs_n;
    logic din;
    logic dout_o;
    logic dout_oe_n;
    logic strap_lo;
    logic [71:0] rx;
    int n_fail;
    int checks_done;
    // The pin floats while the slave has released it.
    wire pin = dout_oe_n ? 1'bz : dout_o;
    afs_spi_slave u_afs_spi_slave (.clk(clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n),
        .din(din), .dout_o(dout_o), .dout_oe_n(dout_oe_n), .strap_select_low(strap_lo),
        .strap_select_high(1'b0), .conv_result_valid(conv_result_valid),
        .conv_result(conv_result));
    afs_host_model u_afs_host_model (.sclk(sclk), .cs_n(cs_n), .din(din), .pin(pin));
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Independent checksum: polynomial 0x07, zero start, command and data.
    function automatic logic [7:0] crc8(input logic [23:0] v);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 23; i >= 0; i--)
            c = {c[6:0], 1'b0} ^ ((c[7] ^ v[i]) ? 8'h07 : 8'h00);
        return c;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // Writes a word; bad flips checksum bits to force a mismatch.
    task automatic wr(input logic [7:0] cmd, input logic [15:0] d, input bit crc, input logic [7:0] bad);
        u_afs_host_model.xfer({40'h0, cmd, d, crc8({cmd, d}) ^ bad} >> (crc ? 0 : 8),
            crc ? 32 : 24, rx);
        chk({31'h0, dout_oe_n}, 32'h1, "pin released");
    endtask
    // Reads a word and, when enabled, its polynomial checksum.
    task automatic rd(input logic [7:0] cmd, input bit crc, input logic [15:0] exp);
        u_afs_host_model.xfer({40'h0, cmd, 24'h0} >> (crc ? 0 : 8), crc ? 32 : 24, rx);
        chk({16'h0, crc ? rx[23:8] : rx[15:0]}, {16'h0, exp}, "read data");
        if (crc)
            chk({24'h0, rx[7:0]}, {24'h0, crc8({cmd, exp})}, "read checksum");
    endtask
    // Result read: ready level at the eighth edge, then the word.
    task automatic rdres(input logic rdy, input logic [23:0] exp);
        u_afs_host_model.xfer({40'h0, 8'h44, 24'h0}, 32, rx);
        chk({31'h0, rx[24]}, {31'h0, rdy}, "ready level");
        chk({8'h0, rx[23:0]}, {8'h0, exp}, "result");
    endtask
    task automatic pulse(input logic [23:0] v);
        @(posedge clk);
        conv_result_valid <= 1'b1;
        conv_result <= v;
        @(posedge clk);
        conv_result_valid <= 1'b0;
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_regs();
        rd(8'hC1, 0, REG_RESET);
        wr(8'h81, 16'h1234, 0, 8'h00);
        rd(8'hC1, 0, 16'h1234);
        wr(8'h02, 16'h0008, 0, 8'h00);
        rd(8'h42, 0, 16'h0008);
        $display("test regs done");
    endtask
    // Frames cut short must leave the register alone.
    task automatic t_short();
        u_afs_host_model.xfer({52'h0, 8'h81, 12'hBEE}, 20, rx);
        rd(8'hC1, 0, 16'h1234);
        u_afs_host_model.xfer({56'h0, 8'hC1, 8'h00}, 16, rx);
        rd(8'hC1, 0, 16'h1234);
        $display("test short done");
    endtask
    // A foreign select takes the pin away and writes nothing.
    task automatic t_owner();
        u_afs_host_model.xfer({48'h0, 8'h91, 16'hFFFF}, 24, rx);
        chk({16'h0, rx[15:0]}, {16'h0, 16'hzzzz}, "pin handed over");
        rd(8'hC1, 0, 16'h1234);
        // Strapped to 01, the pin is released from the third command bit until its own command lands.
        @(posedge clk);
        strap_lo <= 1'b1;
        rd(8'hD1, 0, 16'h1234);
        chk({26'h0, rx[21:16]}, {26'h0, 6'bzzzzzz}, "pin held back");
        @(posedge clk);
        strap_lo <= 1'b0;
        $display("test owner done");
    endtask
    task automatic t_crc();
        wr(8'h81, 16'h2000, 0, 8'h00);
        rd(8'hC1, 1, 16'h2000);
        wr(8'h81, 16'h2055, 1, 8'h00);
        rd(8'hC1, 1, 16'h2055);
        wr(8'h81, 16'h6000, 1, 8'h01);
        rd(8'hC1, 1, 16'h2055);
        rd(8'hC0, 1, 16'h0010);
        wr(8'h02, 16'h0008, 1, 8'h01);
        rd(8'h40, 1, 16'h0020);
        // Converter reads switch to a bytewise XOR checksum.
        wr(8'h02, 16'h0004, 1, 8'h00);
        u_afs_host_model.xfer({40'h0, 8'h42, 24'h0}, 32, rx);
        chk({8'h0, rx[23:0]}, {8'h0, 16'h0004, 8'h46}, "xor checksum");
        u_afs_host_model.xfer({72{1'b1}}, 64, rx);
        rd(8'hC0, 0, REG_RESET);
        rd(8'hC1, 0, REG_RESET);
        $display("test crc done");
    endtask
    task automatic t_result();
        // Ready starts low, so the first result waits out the lead time.
        pulse(24'hA5C3E1);
        repeat (300) @(posedge clk);
        rdres(1'b0, 24'hA5C3E1);
        pulse(24'h123456);
        repeat (20) @(posedge clk);
        pulse(24'h654321);
        repeat (40) @(posedge clk);
        u_afs_host_model.xfer({64'h0, 8'hC1}, 8, rx);
        chk({31'h0, rx[0]}, 32'h1, "ready raised early");
        repeat (200) @(posedge clk);
        rdres(1'b0, 24'h654321);
        fork
            rdres(1'b1, 24'h654321);
            begin
                repeat (120) @(posedge clk);
                pulse(24'h0F0F0F);
            end
        join
        rdres(1'b1, 24'h654321);
        $display("test result done");
    endtask
    // ----------------------------------------------------------------
    // Run control
    // ----------------------------------------------------------------
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    always #5 clk = ~clk;
    initial
    begin
        clk = 1'b0;
        rst_n = 1'b0;
        conv_result_valid = 1'b0;
        conv_result = '0;
        strap_lo = 1'b0;
        n_fail = 0;
        checks_done = 0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        t_regs();
        t_short();
        t_owner();
        t_crc();
        t_result();
        end_sim();
    end
    // A hang counts as a mismatch and closes the run.
    initial
    begin
        #500000;
        n_fail++;
        end_sim();
    end
endmodule // tb_adc_frontend_spi_slave
